/* File: rtl/jflm_pkg.sv */
`default_nettype none
package jflm_pkg;
	localparam int JFLM_LANES = 4;
	localparam int JFLM_WORD_W = 64;
	localparam int JFLM_FIFO_DEPTH = 16;
	localparam logic [11:0] JFLM_CFG_OFS = 12'h000;
	localparam logic [11:0] JFLM_STAT_OFS = 12'h004;
	localparam logic [31:0] JFLM_CFG_RST = 32'h0000_0000;
	localparam int JFLM_CFG_M0_LSB = 0;
	localparam int JFLM_CFG_M1_LSB = 2;
	localparam int JFLM_CFG_M2_LSB = 4;
	localparam int JFLM_CFG_TW_LSB = 6;
	localparam int JFLM_CFG_DEC_LSB = 8;
	localparam int JFLM_CFG_EN_BIT = 16;
	localparam int JFLM_STAT_DEV_OK_BIT = 0;
	localparam int JFLM_STAT_CFG_OK_BIT = 1;
	localparam int JFLM_STAT_CNT_LSB = 16;
	localparam logic [5:0] JFLM_DEC_BYPASS = 6'h00;
	localparam logic [5:0] JFLM_DEC_24 = 6'h18;
	localparam logic [5:0] JFLM_DEC_32 = 6'h20;
	localparam logic [1:0] JFLM_TW_ON = 2'h3;
	localparam logic [5:0] JFLM_PLL_16X = 6'h10;
	localparam logic [5:0] JFLM_PLL_20X = 6'h14;
	localparam logic [5:0] JFLM_PLL_40X = 6'h28;

	typedef logic [19:0][15:0] jflm_sbuf_t;
	typedef logic [3:0][63:0] jflm_lstr_t;
	typedef enum logic [2:0] {
		JFLM_FMT_NONE = 3'h0,
		JFLM_FMT_B14 = 3'h1,
		JFLM_FMT_B12 = 3'h2,
		JFLM_FMT_8411 = 3'h3,
		JFLM_FMT_8422 = 3'h4,
		JFLM_FMT_4421 = 3'h5,
		JFLM_FMT_4442 = 3'h6,
		JFLM_FMT_2441 = 3'h7
	} jflm_fmt_t;

	// Field settings to frame format; anything off the list is NONE
	function automatic jflm_fmt_t jflm_decode(logic [5:0] dec, logic [1:0] m0, logic [1:0] m1,
			logic [1:0] m2, logic [1:0] tw);
		jflm_fmt_t f;
		logic d46;
		logic dmid;
		f = JFLM_FMT_NONE;
		d46 = dec == 6'h04 || dec == 6'h06;
		dmid = dec inside {6'h08, 6'h09, 6'h0a, 6'h0c, 6'h10, 6'h12, 6'h14};
		if (dec == JFLM_DEC_BYPASS) begin
			if (tw == JFLM_TW_ON && m0 == 2'h3 && m1 == 2'h0 && m2 == 2'h0)
				f = JFLM_FMT_B12;
			else if (tw == 2'h0 && m0 == 2'h1 && m1 == 2'h0 && m2 == 2'h0)
				f = JFLM_FMT_B14;
		end else if (tw == 2'h0) begin
			case ({m0, m1, m2})
				6'h14: f = d46 ? JFLM_FMT_8411 : JFLM_FMT_NONE;
				6'h10: f = d46 ? JFLM_FMT_8422 : (dmid || dec == JFLM_DEC_24) ? JFLM_FMT_4421 : JFLM_FMT_NONE;
				6'h01: f = d46 ? JFLM_FMT_4421 : JFLM_FMT_NONE;
				6'h20: f = d46 ? JFLM_FMT_4442 : (dmid || dec == JFLM_DEC_32) ? JFLM_FMT_2441 : JFLM_FMT_NONE;
				default: f = JFLM_FMT_NONE;
			endcase
		end
		return f;
	endfunction : jflm_decode

	// PLL multiplier that goes with each format
	function automatic logic [5:0] jflm_pll(jflm_fmt_t f, logic [5:0] dec);
		case (f)
			JFLM_FMT_B12: return JFLM_PLL_16X;
			JFLM_FMT_B14, JFLM_FMT_8411, JFLM_FMT_8422: return JFLM_PLL_20X;
			JFLM_FMT_4421: return (dec < 6'h08) ? JFLM_PLL_40X : JFLM_PLL_20X;
			JFLM_FMT_4442, JFLM_FMT_2441: return JFLM_PLL_40X;
			default: return 6'h00;
		endcase
	endfunction : jflm_pll

	// Octets per lane per frame
	function automatic logic [3:0] jflm_octets(jflm_fmt_t f);
		case (f)
			JFLM_FMT_B12: return 4'h8;
			JFLM_FMT_8411: return 4'h1;
			JFLM_FMT_4442, JFLM_FMT_2441: return 4'h4;
			default: return 4'h2;
		endcase
	endfunction : jflm_octets

	// Samples per channel per frame
	function automatic logic [4:0] jflm_samples(jflm_fmt_t f);
		case (f)
			JFLM_FMT_B14: return 5'h04;
			JFLM_FMT_B12: return 5'h14;
			JFLM_FMT_8422, JFLM_FMT_4442: return 5'h02;
			default: return 5'h01;
		endcase
	endfunction : jflm_samples
endpackage : jflm_pkg
`default_nettype wire

/* File: rtl/jflm_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Transport link between the framer and the receiver, one pclk domain
interface jflm_if;
	logic [1:0] format_select_field_0;
	logic [1:0] format_select_field_1;
	logic [1:0] format_select_field_2;
	logic [1:0] twelve_bit_field;
	logic [5:0] decim_factor;
	logic fmt_ok;
	logic frame_start;
	logic octet_valid;
	logic [7:0] chan_a_lane_0;
	logic [7:0] chan_a_lane_1;
	logic [7:0] chan_a_lane_2;
	logic [7:0] chan_a_lane_3;
	logic [7:0] chan_b_lane_0;
	logic [7:0] chan_b_lane_1;
	logic [7:0] chan_b_lane_2;
	logic [7:0] chan_b_lane_3;

	modport tx (
		input format_select_field_0, format_select_field_1, format_select_field_2,
		input twelve_bit_field, decim_factor,
		output fmt_ok, frame_start, octet_valid,
		output chan_a_lane_0, chan_a_lane_1, chan_a_lane_2, chan_a_lane_3,
		output chan_b_lane_0, chan_b_lane_1, chan_b_lane_2, chan_b_lane_3
	);
	modport rx (
		output format_select_field_0, format_select_field_1, format_select_field_2,
		output twelve_bit_field, decim_factor,
		input fmt_ok, frame_start, octet_valid,
		input chan_a_lane_0, chan_a_lane_1, chan_a_lane_2, chan_a_lane_3,
		input chan_b_lane_0, chan_b_lane_1, chan_b_lane_2, chan_b_lane_3
	);
endinterface : jflm_if
`default_nettype wire

/* File: rtl/jflm_tx.sv */
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO; DEPTH must be a power of two so the pointers wrap freely
module jflm_fifo #(
	parameter int W = 64,
	parameter int DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} jflm_fifo_st_t;
	jflm_fifo_st_t s_r, s_nxt;
	logic push;
	logic pop;

	// Full and empty straight from the occupancy count
	assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
	assign out_valid = s_r.cnt != '0;
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Next state
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : jflm_fifo

////////////////////////////////////////////////////////////////////////////////
// Frame assembler: collects one frame of samples, then sends it octet by octet
module jflm_tx
	import jflm_pkg::*;
#(
	parameter int DEPTH = JFLM_FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	input wire logic [JFLM_WORD_W-1:0] in_data,
	output logic in_ready,
	output logic [5:0] pll_mult,
	output logic fmt_err,
	jflm_if.tx link
);
	typedef enum logic {
		JFLM_TX_COLLECT = 1'b0,
		JFLM_TX_SEND = 1'b1
	} jflm_tx_state_t;
	typedef struct packed {
		jflm_tx_state_t st;
		jflm_fmt_t fmt;
		logic [4:0] cnt;
		logic [2:0] oct;
		jflm_sbuf_t ai;
		jflm_sbuf_t aq;
		jflm_sbuf_t bi;
		jflm_sbuf_t bq;
		logic [7:0][7:0] lane;
		logic ovalid;
		logic fstart;
		logic ok;
		logic [5:0] pll;
	} jflm_tx_st_t;

	jflm_tx_st_t s_r, s_nxt;
	jflm_fmt_t fmt_now;
	jflm_fmt_t cur;
	logic f_valid;
	logic f_pop;
	logic [JFLM_WORD_W-1:0] f_data;
	logic [63:0] str_a;
	logic [63:0] str_b;

	// One lane's frame, left-justified, octet 0 in bits 63:56
	function automatic logic [63:0] jflm_lane_pack(jflm_fmt_t f, logic [1:0] ln, jflm_sbuf_t ib, jflm_sbuf_t qb);
		logic [63:0] s;
		logic [4:0] b;
		logic [15:0] w;
		s = 64'h0;
		b = 5'(ln) * 5'h05;
		w = ln[1] ? qb[ln[0]] : ib[ln[0]];
		case (f)
			// sample n split over lane n
			JFLM_FMT_B14: s[63:48] = {ib[ln][13:0], 2'b00};
			JFLM_FMT_B12: s = {ib[b][13:2], ib[b + 5'h01][13:2], ib[b + 5'h02][13:2],
				ib[b + 5'h03][13:2], ib[b + 5'h04][13:2], 4'h0};
			JFLM_FMT_8411: s[63:56] = ln[0] ? (ln[1] ? qb[0][7:0] : ib[0][7:0])
				: (ln[1] ? qb[0][15:8] : ib[0][15:8]);
			JFLM_FMT_8422: s[63:48] = w;
			JFLM_FMT_4421: s[63:48] = ln[1] ? 16'h0 : (ln[0] ? qb[0] : ib[0]);
			JFLM_FMT_4442: s[63:32] = ln[1] ? 32'h0 : (ln[0] ? {qb[0], qb[1]} : {ib[0], ib[1]});
			JFLM_FMT_2441: s[63:32] = (ln == 2'h0) ? {ib[0], qb[0]} : 32'h0;
			default: s = 64'h0;
		endcase
		return s;
	endfunction : jflm_lane_pack

	// Buffer ahead of the framer; it stalls while a frame is on the lanes
	jflm_fifo #(
		.W(JFLM_WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(in_valid),
		.in_data(in_data),
		.in_ready(in_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_pop)
	);

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ovalid = 1'b0;
		s_nxt.fstart = 1'b0;
		str_a = 64'h0;
		str_b = 64'h0;
		f_pop = 1'b0;
		fmt_now = jflm_decode(link.decim_factor, link.format_select_field_0, link.format_select_field_1,
			link.format_select_field_2, link.twelve_bit_field);
		s_nxt.ok = fmt_now != JFLM_FMT_NONE;
		// Format is sampled at the first sample of a frame and held to its end
		cur = (s_r.cnt == 5'h00) ? fmt_now : s_r.fmt;
		case (s_r.st)
			JFLM_TX_COLLECT: begin
				f_pop = f_valid && cur != JFLM_FMT_NONE;
				if (f_pop) begin
					s_nxt.fmt = cur;
					s_nxt.pll = jflm_pll(cur, link.decim_factor);
					s_nxt.ai[s_r.cnt] = f_data[63:48];
					s_nxt.aq[s_r.cnt] = f_data[47:32];
					s_nxt.bi[s_r.cnt] = f_data[31:16];
					s_nxt.bq[s_r.cnt] = f_data[15:0];
					if (s_r.cnt == jflm_samples(cur) - 5'h01) begin
						s_nxt.st = JFLM_TX_SEND;
						s_nxt.cnt = 5'h00;
						s_nxt.oct = 3'h0;
					end else begin
						s_nxt.cnt = s_r.cnt + 5'h01;
					end
				end
			end
			JFLM_TX_SEND: begin
				for (int l = 0; l < JFLM_LANES; l++) begin
					str_a = jflm_lane_pack(s_r.fmt, 2'(l), s_r.ai, s_r.aq);
					str_b = jflm_lane_pack(s_r.fmt, 2'(l), s_r.bi, s_r.bq);
					s_nxt.lane[l] = str_a[{~s_r.oct, 3'b000} +: 8];
					s_nxt.lane[l + JFLM_LANES] = str_b[{~s_r.oct, 3'b000} +: 8];
				end
				s_nxt.ovalid = 1'b1;
				s_nxt.fstart = s_r.oct == 3'h0;
				if (s_r.oct == 3'(jflm_octets(s_r.fmt) - 4'h1)) begin
					s_nxt.st = JFLM_TX_COLLECT;
				end else begin
					s_nxt.oct = s_r.oct + 3'h1;
				end
			end
			default: s_nxt.st = JFLM_TX_COLLECT;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Link and status outputs, all from flops
	assign link.fmt_ok = s_r.ok;
	assign link.frame_start = s_r.fstart;
	assign link.octet_valid = s_r.ovalid;
	assign link.chan_a_lane_0 = s_r.lane[0];
	assign link.chan_a_lane_1 = s_r.lane[1];
	assign link.chan_a_lane_2 = s_r.lane[2];
	assign link.chan_a_lane_3 = s_r.lane[3];
	assign link.chan_b_lane_0 = s_r.lane[4];
	assign link.chan_b_lane_1 = s_r.lane[5];
	assign link.chan_b_lane_2 = s_r.lane[6];
	assign link.chan_b_lane_3 = s_r.lane[7];
	assign pll_mult = s_r.pll;
	assign fmt_err = !s_r.ok;
endmodule : jflm_tx
`default_nettype wire

/* File: rtl/jflm_rx.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Receiver end: configures the framer over APB, gathers lanes, rebuilds samples
module jflm_rx
	import jflm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic out_valid,
	output logic [JFLM_WORD_W-1:0] out_data,
	jflm_if.rx link
);
	typedef enum logic {
		JFLM_RX_RECV = 1'b0,
		JFLM_RX_EMIT = 1'b1
	} jflm_rx_state_t;
	typedef struct packed {
		jflm_rx_state_t st;
		jflm_fmt_t fmt;
		logic [2:0] oct;
		logic [4:0] idx;
		jflm_lstr_t sa;
		jflm_lstr_t sb;
		logic [31:0] cfg;
		logic [15:0] frames;
		logic [31:0] rdata;
		logic [63:0] odata;
		logic ovalid;
	} jflm_rx_st_t;

	jflm_rx_st_t s_r, s_nxt;
	jflm_fmt_t cfg_fmt;
	jflm_fmt_t f;
	logic run;
	logic [2:0] o;
	logic [3:0][7:0] la;
	logic [3:0][7:0] lb;

	// Sample idx of a frame from its lane streams, {I, Q}
	function automatic logic [31:0] jflm_unpack(jflm_fmt_t fm, logic [4:0] idx, jflm_lstr_t st);
		logic [63:0] sel;
		logic [2:0] m;
		sel = st[2'(idx / 5'h05)];
		m = 3'(idx % 5'h05);
		sel = sel << (6'(m) * 6'h0c);
		case (fm)
			JFLM_FMT_B14: return {2'b00, st[idx[1:0]][63:50], 16'h0};
			JFLM_FMT_B12: return {2'b00, sel[63:52], 2'b00, 16'h0};
			JFLM_FMT_8411: return {st[0][63:56], st[1][63:56], st[2][63:56], st[3][63:56]};
			JFLM_FMT_8422: return {st[{1'b0, idx[0]}][63:48], st[{1'b1, idx[0]}][63:48]};
			JFLM_FMT_4421: return {st[0][63:48], st[1][63:48]};
			JFLM_FMT_4442: return idx[0] ? {st[0][47:32], st[1][47:32]} : {st[0][63:48], st[1][63:48]};
			JFLM_FMT_2441: return st[0][63:32];
			default: return 32'h0;
		endcase
	endfunction : jflm_unpack

	assign la = {link.chan_a_lane_3, link.chan_a_lane_2, link.chan_a_lane_1, link.chan_a_lane_0};
	assign lb = {link.chan_b_lane_3, link.chan_b_lane_2, link.chan_b_lane_1, link.chan_b_lane_0};

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ovalid = 1'b0;
		cfg_fmt = jflm_decode(s_r.cfg[JFLM_CFG_DEC_LSB +: 6], s_r.cfg[JFLM_CFG_M0_LSB +: 2],
			s_r.cfg[JFLM_CFG_M1_LSB +: 2], s_r.cfg[JFLM_CFG_M2_LSB +: 2], s_r.cfg[JFLM_CFG_TW_LSB +: 2]);
		// only listed settings, enabled and acknowledged, are run
		run = s_r.cfg[JFLM_CFG_EN_BIT] && cfg_fmt != JFLM_FMT_NONE && link.fmt_ok;
		o = link.frame_start ? 3'h0 : s_r.oct;
		f = link.frame_start ? cfg_fmt : s_r.fmt;
		// Register writes land in the access phase
		if (psel && penable && pwrite && paddr == JFLM_CFG_OFS) begin
			s_nxt.cfg = pwdata;
		end
		// Read data is staged in the setup cycle
		if (psel && !penable) begin
			s_nxt.rdata = 32'h0;
			if (paddr == JFLM_CFG_OFS) begin
				s_nxt.rdata = s_r.cfg;
			end else if (paddr == JFLM_STAT_OFS) begin
				s_nxt.rdata[JFLM_STAT_DEV_OK_BIT] = link.fmt_ok;
				s_nxt.rdata[JFLM_STAT_CFG_OK_BIT] = cfg_fmt != JFLM_FMT_NONE;
				s_nxt.rdata[JFLM_STAT_CNT_LSB +: 16] = s_r.frames;
			end
		end
		case (s_r.st)
			JFLM_RX_RECV: begin
				// Octets outside a started frame are dropped
				if (run && link.octet_valid && (link.frame_start || s_r.oct != 3'h0)) begin
					s_nxt.fmt = f;
					for (int l = 0; l < JFLM_LANES; l++) begin
						s_nxt.sa[l][{~o, 3'b000} +: 8] = la[l];
						s_nxt.sb[l][{~o, 3'b000} +: 8] = lb[l];
					end
					if (o == 3'(jflm_octets(f) - 4'h1)) begin
						s_nxt.st = JFLM_RX_EMIT;
						s_nxt.idx = 5'h00;
						s_nxt.oct = 3'h0;
						s_nxt.frames = s_r.frames + 16'h0001;
					end else begin
						s_nxt.oct = o + 3'h1;
					end
				end
			end
			JFLM_RX_EMIT: begin
				s_nxt.ovalid = 1'b1;
				s_nxt.odata = {jflm_unpack(s_r.fmt, s_r.idx, s_r.sa), jflm_unpack(s_r.fmt, s_r.idx, s_r.sb)};
				if (s_r.idx == jflm_samples(s_r.fmt) - 5'h01) begin
					s_nxt.st = JFLM_RX_RECV;
				end else begin
					s_nxt.idx = s_r.idx + 5'h01;
				end
			end
			default: s_nxt.st = JFLM_RX_RECV;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.cfg <= JFLM_CFG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Zero-wait slave; unmapped words answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && paddr != JFLM_CFG_OFS && paddr != JFLM_STAT_OFS;
	assign prdata = s_r.rdata;
	assign out_valid = s_r.ovalid;
	assign out_data = s_r.odata;
	assign link.format_select_field_0 = s_r.cfg[JFLM_CFG_M0_LSB +: 2];
	assign link.format_select_field_1 = s_r.cfg[JFLM_CFG_M1_LSB +: 2];
	assign link.format_select_field_2 = s_r.cfg[JFLM_CFG_M2_LSB +: 2];
	assign link.twelve_bit_field = s_r.cfg[JFLM_CFG_TW_LSB +: 2];
	assign link.decim_factor = s_r.cfg[JFLM_CFG_DEC_LSB +: 6];
endmodule : jflm_rx
`default_nettype wire

/* File: dv/jflm_chk.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Link watcher: frame lengths, tail bits and field decode
module jflm_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] format_select_field_0,
	input wire logic [1:0] format_select_field_1,
	input wire logic [1:0] format_select_field_2,
	input wire logic [1:0] twelve_bit_field,
	input wire logic [5:0] decim_factor,
	input wire logic fmt_ok,
	input wire logic frame_start,
	input wire logic octet_valid,
	input wire logic [7:0] chan_a_lane_0,
	input wire logic [7:0] chan_a_lane_1,
	input wire logic [7:0] chan_a_lane_2,
	input wire logic [7:0] chan_a_lane_3,
	input wire logic [7:0] chan_b_lane_0,
	input wire logic [7:0] chan_b_lane_1,
	input wire logic [7:0] chan_b_lane_2,
	input wire logic [7:0] chan_b_lane_3
);
	logic [7:0] fs;
	logic [63:0] ln;
	logic byp, tl2, tl4;
	// Fields packed as {twelve-bit, f0, f1, f2}
	assign fs = {twelve_bit_field, format_select_field_0, format_select_field_1, format_select_field_2};
	assign byp = decim_factor == 6'h00;
	assign ln = {chan_a_lane_0, chan_a_lane_1, chan_a_lane_2, chan_a_lane_3,
		chan_b_lane_0, chan_b_lane_1, chan_b_lane_2, chan_b_lane_3};
	// Low bits of every lane, for tail checks
	always_comb begin
		tl2 = 1'b0;
		tl4 = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tl2 = tl2 | (|ln[8*i +: 2]);
			tl4 = tl4 | (|ln[8*i +: 4]);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_valid: assert property (frame_start |-> octet_valid)
		else $error("frame start without octet");
	a_start_single: assert property (frame_start |=> !frame_start)
		else $error("frame start twice in a row");
	a_len_b14: assert property (frame_start && byp && fs == 8'h10 |-> octet_valid[*2] ##1 !octet_valid)
		else $error("14-bit frame not two octets");
	a_len_b12: assert property (frame_start && byp && fs == 8'hf0 |-> octet_valid[*8] ##1 !octet_valid)
		else $error("12-bit frame not eight octets");
	a_len_one: assert property (frame_start && !byp && fs == 8'h14 |=> !octet_valid)
		else $error("one-octet frame too long");
	a_len_four: assert property (frame_start && !byp && fs == 8'h20 |-> octet_valid[*4] ##1 !octet_valid)
		else $error("four-octet frame wrong length");
	a_tail_b14: assert property (frame_start && byp && fs == 8'h10 |=> !tl2)
		else $error("14-bit tail bits not zero");
	a_tail_b12: assert property (frame_start && byp && fs == 8'hf0 |-> ##7 !tl4)
		else $error("12-bit tail nibble not zero");
	a_idle_lanes: assert property (octet_valid && !byp && fs == 8'h20 |-> ln[47:32] == 16'h0 && ln[15:0] == 16'h0)
		else $error("unused lane not zero");
	a_ok_b14: assert property (byp && fs == 8'h10 |=> fmt_ok)
		else $error("14-bit fields not accepted");
	a_ok_bad: assert property (decim_factor == 6'h18 && fs == 8'h20 |=> !fmt_ok)
		else $error("illegal fields accepted");
endmodule : jflm_chk
`default_nettype wire

/* File: dv/jflm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module jflm_tb import jflm_pkg::*; ;
	logic pclk = 1'b0;
	logic presetn, in_valid, psel, penable, pwrite, in_ready, fmt_err, pready, pslverr, out_valid;
	logic [63:0] in_data, out_data;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, st;
	logic [5:0] pll_mult;
	logic e;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int oi = 0;
	int dm[7] = '{8, 9, 10, 12, 16, 18, 20};
	logic [63:0] cap[8];
	logic [63:0] rq[$];

	jflm_if lk();
	jflm_tx #(.DEPTH(JFLM_FIFO_DEPTH)) i_jflm_tx (.pclk(pclk), .presetn(presetn), .in_valid(in_valid),
		.in_data(in_data), .in_ready(in_ready), .pll_mult(pll_mult), .fmt_err(fmt_err), .link(lk));
	jflm_rx i_jflm_rx (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.out_valid(out_valid), .out_data(out_data), .link(lk));
	jflm_chk i_jflm_chk (.pclk(pclk), .presetn(presetn), .format_select_field_0(lk.format_select_field_0),
		.format_select_field_1(lk.format_select_field_1), .format_select_field_2(lk.format_select_field_2),
		.twelve_bit_field(lk.twelve_bit_field), .decim_factor(lk.decim_factor), .fmt_ok(lk.fmt_ok),
		.frame_start(lk.frame_start), .octet_valid(lk.octet_valid), .chan_a_lane_0(lk.chan_a_lane_0),
		.chan_a_lane_1(lk.chan_a_lane_1), .chan_a_lane_2(lk.chan_a_lane_2), .chan_a_lane_3(lk.chan_a_lane_3),
		.chan_b_lane_0(lk.chan_b_lane_0), .chan_b_lane_1(lk.chan_b_lane_1), .chan_b_lane_2(lk.chan_b_lane_2),
		.chan_b_lane_3(lk.chan_b_lane_3));

	always #12.5 pclk = ~pclk;

	// Capture link octets and rebuilt samples; cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (out_valid === 1'b1)
			rq.push_back(out_data);
		if (lk.octet_valid === 1'b1) begin
			oi = (lk.frame_start === 1'b1) ? 0 : oi + 1;
			cap[oi[2:0]] = {lk.chan_a_lane_0, lk.chan_a_lane_1, lk.chan_a_lane_2, lk.chan_a_lane_3,
				lk.chan_b_lane_0, lk.chan_b_lane_1, lk.chan_b_lane_2, lk.chan_b_lane_3};
		end
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// Sample word i; no field is all zero
	function automatic logic [63:0] wd(int i);
		return {16'h1234 * 16'(i) + 16'hf3c5, 16'h2b1d + 16'(i) * 16'h0111,
			16'h0e57 * 16'(i) + 16'h3a96, 16'h1357 + 16'(i)};
	endfunction : wd

	function automatic logic [13:0] smp(int c, int i);
		logic [63:0] w;
		w = wd(i);
		return c ? w[29:16] : w[61:48];
	endfunction : smp

	// Octets 0..f-1 of lane l, earliest octet highest
	function automatic logic [63:0] lst(int l, int f);
		logic [63:0] r;
		r = 64'h0;
		for (int o = 0; o < f; o++)
			r = {r[55:0], cap[o][63-8*l -: 8]};
		return r;
	endfunction : lst

	function automatic logic [31:0] cfg(logic [5:0] d, logic [1:0] tw, logic [1:0] f0, logic [1:0] f1,
			logic [1:0] f2);
		return (32'(d) << JFLM_CFG_DEC_LSB) | (32'(tw) << JFLM_CFG_TW_LSB) | (32'(f0) << JFLM_CFG_M0_LSB) |
			(32'(f1) << JFLM_CFG_M1_LSB) | (32'(f2) << JFLM_CFG_M2_LSB) | (32'h1 << JFLM_CFG_EN_BIT);
	endfunction : cfg

	task chk(string nm, logic [63:0] ex, logic [63:0] sn);
		cmp_count++;
		if (ex !== sn) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, ex, sn);
		end
	endtask : chk

	// One APB transfer, then an idle edge so strobes never change twice at once
	task apb(bit wr, logic [11:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Decode is registered, so let it settle
	task cfgw(logic [31:0] v);
		apb(1'b1, JFLM_CFG_OFS, v, q, e);
		repeat (2) @(posedge pclk);
	endtask : cfgw

	task push(int n);
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_data <= wd(i);
			do @(posedge pclk); while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
	endtask : push

	task waitq(int n);
		int t;
		t = 0;
		while (rq.size() < n && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		chk("samples", 64'(n), 64'(rq.size()));
	endtask : waitq

	task byp(bit b12);
		int s;
		logic [63:0] sr;
		logic [13:0] x, m;
		s = b12 ? 20 : 4;
		m = b12 ? 14'h3ffc : 14'h3fff;
		rq.delete();
		cfgw(b12 ? cfg(6'h00, 2'h3, 2'h3, 2'h0, 2'h0) : cfg(6'h00, 2'h0, 2'h1, 2'h0, 2'h0));
		push(s);
		waitq(s);
		chk("pll", b12 ? JFLM_PLL_16X : JFLM_PLL_20X, pll_mult);
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 4; k++) begin
				sr = 64'h0;
				for (int j = 0; j < 5; j++) begin
					x = smp(c, 5 * k + j);
					sr = {sr[51:0], x[13:2]};
				end
				if (b12)
					chk("lane12", {sr[59:0], 4'h0}, lst(4 * c + k, 8));
				else
					chk("lane14", {smp(c, k), 2'b00}, lst(4 * c + k, 2));
			end
		end
		for (int i = 0; i < s; i++)
			chk("rx", {2'b00, smp(0, i) & m, 16'h0, 2'b00, smp(1, i) & m, 16'h0}, rq[i]);
	endtask : byp

	task cplx(logic [5:0] d, logic [1:0] f0, logic [1:0] f1, logic [1:0] f2, int s, int f, logic [5:0] pll, int k);
		logic [15:0] i0, q0, i1, q1;
		logic [63:0] e0, e1, w0, w1;
		w0 = wd(0);
		w1 = wd(1);
		rq.delete();
		cfgw(cfg(d, 2'h0, f0, f1, f2));
		push(s);
		waitq(s);
		chk("pll", pll, pll_mult);
		for (int c = 0; c < 2; c++) begin
			{i0, q0} = c ? w0[31:0] : w0[63:32];
			{i1, q1} = c ? w1[31:0] : w1[63:32];
			case (k)
				0: begin e0 = i0[15:8]; e1 = i0[7:0]; end
				1: begin e0 = i0; e1 = i1; end
				2: begin e0 = i0; e1 = q0; end
				3: begin e0 = {i0, i1}; e1 = {q0, q1}; end
				default: begin e0 = {i0, q0}; e1 = 64'h0; end
			endcase
			chk("lane0", e0, lst(4 * c, f));
			chk("lane1", e1, lst(4 * c + 1, f));
		end
		for (int i = 0; i < s; i++)
			chk("rx", wd(i), rq[i]);
	endtask : cplx

	// Reset values, register bus, then an unmapped word
	task reg_basic();
		chk("fmt_err", 64'h1, fmt_err);
		chk("pll", 64'h0, pll_mult);
		apb(1'b0, JFLM_CFG_OFS, 32'h0, q, e);
		chk("cfg", JFLM_CFG_RST, q);
		chk("slverr", 64'h0, e);
		apb(1'b0, 12'h008, 32'h0, q, e);
		chk("slverr", 64'h1, e);
		chk("rd_unmapped", 64'h0, q);
	endtask : reg_basic

	// Illegal fields hold the FIFO until it refuses; a legal format drains it
	task illegal_hold();
		cfgw(cfg(JFLM_DEC_24, 2'h0, 2'h2, 2'h0, 2'h0));
		chk("fmt_err", 64'h1, fmt_err);
		apb(1'b0, JFLM_STAT_OFS, 32'h0, st, e);
		chk("stat_ok", 64'h0, st[1:0]);
		apb(1'b0, JFLM_CFG_OFS, 32'h0, q, e);
		chk("cfg", cfg(JFLM_DEC_24, 2'h0, 2'h2, 2'h0, 2'h0), q);
		rq.delete();
		push(16);
		@(posedge pclk);
		chk("in_ready", 64'h0, in_ready);
		cfgw(cfg(JFLM_DEC_32, 2'h0, 2'h2, 2'h0, 2'h0));
		waitq(16);
		for (int i = 0; i < 16; i++)
			chk("rx", wd(i), rq[i]);
		apb(1'b0, JFLM_STAT_OFS, 32'h0, q, e);
		chk("frames", 16'(st[31:16] + 16'h10), q[31:16]);
		chk("stat_ok", 64'h3, q[1:0]);
	endtask : illegal_hold

	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		presetn = 1'b0;
		{in_valid, psel, penable, pwrite} = 4'h0;
		in_data = 64'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		reg_basic();
		byp(1'b0);
		byp(1'b1);
		cplx(6'h04, 2'h1, 2'h1, 2'h0, 1, 1, JFLM_PLL_20X, 0);
		cplx(6'h06, 2'h1, 2'h0, 2'h0, 2, 2, JFLM_PLL_20X, 1);
		cplx(6'h04, 2'h0, 2'h0, 2'h1, 1, 2, JFLM_PLL_40X, 2);
		cplx(6'h06, 2'h2, 2'h0, 2'h0, 2, 4, JFLM_PLL_40X, 3);
		cplx(JFLM_DEC_24, 2'h1, 2'h0, 2'h0, 1, 2, JFLM_PLL_20X, 2);
		cplx(JFLM_DEC_32, 2'h2, 2'h0, 2'h0, 1, 4, JFLM_PLL_40X, 4);
		// Both offered formats at every middle factor
		foreach (dm[i]) begin
			cplx(6'(dm[i]), 2'h1, 2'h0, 2'h0, 1, 2, JFLM_PLL_20X, 2);
			cplx(6'(dm[i]), 2'h2, 2'h0, 2'h0, 1, 4, JFLM_PLL_40X, 4);
		end
		illegal_hold();
		print_verdict();
	end
endmodule : jflm_tb
`default_nettype wire
